//--- motion_supervisor_map.vh
// Purpose: register map, field positions, reset values for the motion supervisor
// Assumes: APB slave, 32-bit data, one word per register
// Notes: byte offsets
`ifndef MOTION_SUPERVISOR_MAP_VH
`define MOTION_SUPERVISOR_MAP_VH

`define REG_CTRL 8'h00
`define REG_RATE 8'h04
`define REG_HOLD_TIME 8'h08
`define REG_ERR_LIMIT 8'h0C
`define REG_RAMP_UP 8'h10
`define REG_RAMP_DOWN 8'h14
`define REG_STATUS 8'h18
`define REG_POS_ERR 8'h1C

`define CTRL_CHECK_EN 0
`define CTRL_RAMP_UP_EN 1
`define CTRL_RAMP_DOWN_EN 2
`define CTRL_SYNC_PROG 3
`define CTRL_ZERO_REQ 4

`define ST_ERR_FAULT 0
`define ST_NO_FAULT 1
`define ST_SYNC_ACTIVE 2
`define ST_SYNC_UP 3
`define ST_SYNC_AT_RATIO 4
`define ST_SYNC_DOWN 5
`define ST_SYNC_DONE 6
`define ST_HOLD_EFF 7
`define ST_ZERO_REQ 8

`define RATE_RESET 16'h0064
`define RATE_UNITY 16'h0064
`define SYNC_FULL 16'hFFFF
`define HOLD_TIME_RESET 16'h0064
`define RAMP_STEP_RESET 16'h0100

`endif

//--- motion_supervisor.v
// Purpose: hold/rate time base, position error check and electronic gearing supervisor
// Assumes: every CLK_SYS edge is one trajectory update; position in signed 32-bit counts
// Notes: time increment per update = TIME_INC / (100 * HOLD_SPAN); HOLD_SPAN = 0 means full rate
//
// Overview of operation
// - hold decelerates over exact ramp time, move pending
// - hold release reaccelerates over same ramp time
// - held index keeps velocity, then finishes
// - hold hits index, home, program, program jog
// - rate disable runs index/home unscaled
// - time scales by percent, reset 100
// - new percent applies next update
// - position error is command minus feedback, readable
// - fault when checked |error| exceeds limit
// - no-fault ignores travel limit and enable
// - ramp-up step applied only while ramping up
// - ramping-up flag from start until at-ratio
// - assignment activate is level, stops without ramp
// - at-ratio flag shows follower at ratio
// - done flag after stop, until restart
// - active flag throughout gearing, even stationary
// - ramp-down step after gearing off if enabled
// - ramping-down flag from off until done
// - zero request loads feedback, self-clears at zero
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ns
`include "motion_supervisor_map.vh"

module motion_supervisor #(
	parameter POS_W = 32
) (
	// clock and reset
	input wire CLK_SYS,
	input wire SYS_RST,
	// apb slave
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [7:0] PADDR,
	input wire [31:0] PWDATA,
	output reg [31:0] PRDATA,
	output reg PREADY,
	output reg PSLVERR,
	// motion sources
	input wire HOLD_IN,
	input wire RATE_SCALE_DISABLE,
	input wire MOVE_INDEX,
	input wire MOVE_HOME,
	input wire MOVE_PROGRAM,
	input wire MOVE_JOG,
	input wire JOG_FROM_PROGRAM,
	input wire SYNC_ACTIVATE,
	input wire ZERO_ERR_REQ,
	// position and faults
	input wire [POS_W-1:0] POS_COMMAND,
	input wire [POS_W-1:0] POS_FEEDBACK,
	input wire OTHER_FAULT,
	input wire TRAVEL_LIMIT_FAULT,
	// to trajectory generator and drive
	output reg [31:0] TIME_INC,
	output reg [15:0] HOLD_SPAN,
	output reg INDEX_VEL_FREEZE,
	output reg CMD_LOAD,
	output reg [POS_W-1:0] CMD_LOAD_VALUE,
	output reg [15:0] SYNC_SCALE,
	output reg SYNC_ACTIVE,
	output reg SYNC_RAMP_UP,
	output reg SYNC_AT_RATIO,
	output reg SYNC_RAMP_DOWN,
	output reg SYNC_DONE,
	output reg ERR_FAULT,
	output reg NO_FAULT_STATUS
);

	localparam [4:0] S_IDLE = 5'h01;
	localparam [4:0] S_UP = 5'h02;
	localparam [4:0] S_RUN = 5'h04;
	localparam [4:0] S_DOWN = 5'h08;
	localparam [4:0] S_DONE = 5'h10;

	// software registers
	reg check_en_q;
	reg ramp_up_en_q;
	reg ramp_down_en_q;
	reg sync_prog_q;
	reg [15:0] rate_pct_q;
	reg [15:0] hold_time_q;
	reg [POS_W-1:0] err_limit_q;
	reg [15:0] up_step_q;
	reg [15:0] down_step_q;

	// internal state
	reg [15:0] hold_cnt_q;
	reg [15:0] hold_cnt_d;
	reg [4:0] sync_state_q;
	reg [4:0] sync_state_d;
	reg [15:0] sync_lvl_q;
	reg [15:0] sync_lvl_d;
	reg sync_on_q;
	reg act_was_q;
	reg zero_req_q;
	reg [POS_W-1:0] pos_err_q;

	wire wr_en;
	wire rd_en;
	wire addr_ok;
	reg [31:0] rd_data;

	wire [POS_W-1:0] pos_err;
	wire [POS_W-1:0] pos_err_abs;
	wire hold_eff;
	wire [15:0] eff_pct;
	wire sync_on;
	wire sync_start;

	assign wr_en = PSEL & PENABLE & PREADY & PWRITE;
	assign rd_en = PSEL & ~PENABLE & ~PWRITE;
	assign addr_ok = (PADDR == `REG_CTRL) | (PADDR == `REG_RATE) | (PADDR == `REG_HOLD_TIME) |
		(PADDR == `REG_ERR_LIMIT) | (PADDR == `REG_RAMP_UP) | (PADDR == `REG_RAMP_DOWN) |
		(PADDR == `REG_STATUS) | (PADDR == `REG_POS_ERR);

	// error is recomputed every update so reads never lag more than one cycle
	assign pos_err = POS_COMMAND - POS_FEEDBACK;
	assign pos_err_abs = pos_err[POS_W-1] ? (~pos_err + {{(POS_W-1){1'b0}}, 1'b1}) : pos_err;

	// a jog started by hand keeps running through a hold
	assign hold_eff = HOLD_IN & (MOVE_INDEX | MOVE_HOME | MOVE_PROGRAM |
		(MOVE_JOG & JOG_FROM_PROGRAM));

	assign eff_pct = (RATE_SCALE_DISABLE & (MOVE_INDEX | MOVE_HOME)) ?
		`RATE_UNITY : rate_pct_q;

	// assignment level or program initiate both run gearing
	assign sync_on = SYNC_ACTIVATE | sync_prog_q;
	assign sync_start = sync_on & ~sync_on_q;

	// apb register block
	always @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h00000000;
			check_en_q <= 1'b0;
			ramp_up_en_q <= 1'b0;
			ramp_down_en_q <= 1'b0;
			sync_prog_q <= 1'b0;
			rate_pct_q <= `RATE_RESET;
			hold_time_q <= `HOLD_TIME_RESET;
			err_limit_q <= {POS_W{1'b0}};
			up_step_q <= `RAMP_STEP_RESET;
			down_step_q <= `RAMP_STEP_RESET;
		end else begin
			// one access cycle: ready rises in the first access phase
			PREADY <= PSEL & ~PENABLE;
			PSLVERR <= PSEL & ~PENABLE & ~addr_ok;
			if (rd_en) begin
				PRDATA <= rd_data;
			end
			if (wr_en) begin
				case (PADDR)
				`REG_CTRL: begin
					check_en_q <= PWDATA[`CTRL_CHECK_EN];
					ramp_up_en_q <= PWDATA[`CTRL_RAMP_UP_EN];
					ramp_down_en_q <= PWDATA[`CTRL_RAMP_DOWN_EN];
					sync_prog_q <= PWDATA[`CTRL_SYNC_PROG];
				end
				`REG_RATE: begin
					rate_pct_q <= PWDATA[15:0];
				end
				`REG_HOLD_TIME: begin
					hold_time_q <= PWDATA[15:0];
				end
				`REG_ERR_LIMIT: begin
					err_limit_q <= PWDATA[POS_W-1:0];
				end
				`REG_RAMP_UP: begin
					up_step_q <= PWDATA[15:0];
				end
				`REG_RAMP_DOWN: begin
					down_step_q <= PWDATA[15:0];
				end
				default: begin
				end
				endcase
			end
		end
	end

	always @* begin
		rd_data = 32'h00000000;
		case (PADDR)
		`REG_CTRL: begin
			rd_data[`CTRL_CHECK_EN] = check_en_q;
			rd_data[`CTRL_RAMP_UP_EN] = ramp_up_en_q;
			rd_data[`CTRL_RAMP_DOWN_EN] = ramp_down_en_q;
			rd_data[`CTRL_SYNC_PROG] = sync_prog_q;
			rd_data[`CTRL_ZERO_REQ] = zero_req_q;
		end
		`REG_RATE: begin
			rd_data[15:0] = rate_pct_q;
		end
		`REG_HOLD_TIME: begin
			rd_data[15:0] = hold_time_q;
		end
		`REG_ERR_LIMIT: begin
			rd_data[POS_W-1:0] = err_limit_q;
		end
		`REG_RAMP_UP: begin
			rd_data[15:0] = up_step_q;
		end
		`REG_RAMP_DOWN: begin
			rd_data[15:0] = down_step_q;
		end
		`REG_STATUS: begin
			rd_data[`ST_ERR_FAULT] = ERR_FAULT;
			rd_data[`ST_NO_FAULT] = NO_FAULT_STATUS;
			rd_data[`ST_SYNC_ACTIVE] = SYNC_ACTIVE;
			rd_data[`ST_SYNC_UP] = SYNC_RAMP_UP;
			rd_data[`ST_SYNC_AT_RATIO] = SYNC_AT_RATIO;
			rd_data[`ST_SYNC_DOWN] = SYNC_RAMP_DOWN;
			rd_data[`ST_SYNC_DONE] = SYNC_DONE;
			rd_data[`ST_HOLD_EFF] = hold_eff;
			rd_data[`ST_ZERO_REQ] = zero_req_q;
		end
		`REG_POS_ERR: begin
			rd_data[POS_W-1:0] = pos_err_q;
		end
		default: begin
			rd_data = 32'h00000000;
		end
		endcase
	end

	// hold factor walks one step per update, so the stop takes exactly hold_time_q updates
	always @* begin
		hold_cnt_d = hold_cnt_q;
		if (hold_cnt_q > hold_time_q) begin
			hold_cnt_d = hold_time_q;
		end else if (hold_eff) begin
			if (hold_cnt_q != 16'h0000) begin
				hold_cnt_d = hold_cnt_q - 16'h0001;
			end
		end else if (hold_cnt_q != hold_time_q) begin
			hold_cnt_d = hold_cnt_q + 16'h0001;
		end
	end

	always @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			hold_cnt_q <= `HOLD_TIME_RESET;
			TIME_INC <= 32'h00000000;
			HOLD_SPAN <= 16'h0000;
			INDEX_VEL_FREEZE <= 1'b0;
		end else begin
			hold_cnt_q <= hold_cnt_d;
			HOLD_SPAN <= hold_time_q;
			// zero ramp time: hold is an immediate stop, release an immediate resume
			if (hold_time_q == 16'h0000) begin
				TIME_INC <= hold_eff ? 32'h00000000 : {16'h0000, eff_pct};
			end else begin
				TIME_INC <= {16'h0000, eff_pct} * {16'h0000, hold_cnt_d};
			end
			// move stays pending; index velocity is held, not cleared
			INDEX_VEL_FREEZE <= hold_eff & MOVE_INDEX;
		end
	end

	// gearing state machine
	always @* begin
		sync_state_d = sync_state_q;
		sync_lvl_d = sync_lvl_q;
		case (sync_state_q)
		S_IDLE, S_DONE: begin
			if (sync_start) begin
				if (ramp_up_en_q) begin
					sync_state_d = S_UP;
					sync_lvl_d = 16'h0000;
				end else begin
					sync_state_d = S_RUN;
					sync_lvl_d = `SYNC_FULL;
				end
			end
		end
		S_UP: begin
			if (~sync_on) begin
				sync_state_d = S_DONE;
				sync_lvl_d = 16'h0000;
			end else if (up_step_q >= (`SYNC_FULL - sync_lvl_q)) begin
				sync_state_d = S_RUN;
				sync_lvl_d = `SYNC_FULL;
			end else begin
				sync_lvl_d = sync_lvl_q + up_step_q;
			end
		end
		S_RUN: begin
			// dropping the assignment level stops at once when program initiate is off; a program stop may ramp
			if (~sync_on) begin
				if (ramp_down_en_q & ~act_was_q) begin
					sync_state_d = S_DOWN;
				end else begin
					sync_state_d = S_DONE;
					sync_lvl_d = 16'h0000;
				end
			end
		end
		S_DOWN: begin
			if (sync_on) begin
				sync_state_d = ramp_up_en_q ? S_UP : S_RUN;
				sync_lvl_d = ramp_up_en_q ? sync_lvl_q : `SYNC_FULL;
			end else if (down_step_q >= sync_lvl_q) begin
				sync_state_d = S_DONE;
				sync_lvl_d = 16'h0000;
			end else begin
				sync_lvl_d = sync_lvl_q - down_step_q;
			end
		end
		default: begin
			sync_state_d = S_IDLE;
			sync_lvl_d = 16'h0000;
		end
		endcase
	end

	always @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			sync_state_q <= S_IDLE;
			sync_lvl_q <= 16'h0000;
			sync_on_q <= 1'b0;
			act_was_q <= 1'b0;
			SYNC_SCALE <= 16'h0000;
			SYNC_ACTIVE <= 1'b0;
			SYNC_RAMP_UP <= 1'b0;
			SYNC_AT_RATIO <= 1'b0;
			SYNC_RAMP_DOWN <= 1'b0;
			SYNC_DONE <= 1'b0;
		end else begin
			sync_state_q <= sync_state_d;
			sync_lvl_q <= sync_lvl_d;
			sync_on_q <= sync_on;
			act_was_q <= SYNC_ACTIVATE;
			SYNC_SCALE <= sync_lvl_d;
			SYNC_ACTIVE <= (sync_state_d == S_UP) | (sync_state_d == S_RUN) |
				(sync_state_d == S_DOWN);
			SYNC_RAMP_UP <= (sync_state_d == S_UP);
			SYNC_AT_RATIO <= (sync_state_d == S_RUN);
			SYNC_RAMP_DOWN <= (sync_state_d == S_DOWN);
			SYNC_DONE <= (sync_state_d == S_DONE);
		end
	end

	// position error, fault and zero request
	always @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			pos_err_q <= {POS_W{1'b0}};
			zero_req_q <= 1'b0;
			ERR_FAULT <= 1'b0;
			NO_FAULT_STATUS <= 1'b1;
			CMD_LOAD <= 1'b0;
			CMD_LOAD_VALUE <= {POS_W{1'b0}};
		end else begin
			pos_err_q <= pos_err;
			// a new request wins over the release in the same cycle
			if (ZERO_ERR_REQ | (wr_en & (PADDR == `REG_CTRL) & PWDATA[`CTRL_ZERO_REQ])) begin
				zero_req_q <= 1'b1;
			end else if (pos_err == {POS_W{1'b0}}) begin
				zero_req_q <= 1'b0;
			end
			CMD_LOAD <= zero_req_q & (pos_err != {POS_W{1'b0}});
			CMD_LOAD_VALUE <= POS_FEEDBACK;
			// sticky fault: detection wins over a write-one clear
			if (check_en_q & (pos_err_abs > err_limit_q)) begin
				ERR_FAULT <= 1'b1;
			end else if (wr_en & (PADDR == `REG_STATUS) & PWDATA[`ST_ERR_FAULT]) begin
				ERR_FAULT <= 1'b0;
			end
			// travel limit is deliberately left out of this status
			NO_FAULT_STATUS <= ~(ERR_FAULT | OTHER_FAULT);
		end
	end

endmodule

//--- motion_supervisor_properties.sv
// Purpose: port-level properties of the motion supervisor
// Assumes: one clock domain, synchronous active-high reset
// Notes: bound to every instance of the top module
`timescale 1ns/1ns
module sup_props #(
	parameter POS_W = 32
) (
	// clock and reset
	input wire CLK_SYS,
	input wire SYS_RST,
	// inputs watched
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire HOLD_IN,
	input wire MOVE_INDEX,
	input wire SYNC_ACTIVATE,
	input wire ZERO_ERR_REQ,
	input wire [POS_W-1:0] POS_COMMAND,
	input wire [POS_W-1:0] POS_FEEDBACK,
	input wire OTHER_FAULT,
	// outputs watched
	input wire INDEX_VEL_FREEZE,
	input wire CMD_LOAD,
	input wire SYNC_ACTIVE,
	input wire SYNC_RAMP_UP,
	input wire SYNC_AT_RATIO,
	input wire SYNC_RAMP_DOWN,
	input wire SYNC_DONE,
	input wire ERR_FAULT,
	input wire NO_FAULT_STATUS
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (SYS_RST);
	chk_nofault_track: assert property (!$past(SYS_RST) |->
		NO_FAULT_STATUS == !($past(ERR_FAULT) || $past(OTHER_FAULT))) else $error("no-fault wrong");
	chk_fault_sticky: assert property (ERR_FAULT && !(PSEL && PENABLE && PWRITE)
		|=> ERR_FAULT) else $error("fault dropped");
	chk_hold_freeze: assert property (HOLD_IN && MOVE_INDEX |=> INDEX_VEL_FREEZE)
		else $error("index not frozen");
	// request is registered once, then the load is registered
	chk_zero_load: assert property ($rose(ZERO_ERR_REQ) && POS_COMMAND != POS_FEEDBACK
		|-> ##2 CMD_LOAD) else $error("no command load");
	chk_gear_start: assert property ($rose(SYNC_ACTIVATE) |=> SYNC_ACTIVE)
		else $error("gear not active");
	chk_deact_noramp: assert property ($fell(SYNC_ACTIVATE) |=> !SYNC_RAMP_DOWN)
		else $error("assignment stop ramped");
	chk_up_excl: assert property (SYNC_RAMP_UP |-> SYNC_ACTIVE && !SYNC_AT_RATIO)
		else $error("ramp-up flag wrong");
	chk_up_ratio: assert property ($fell(SYNC_RAMP_UP)
		|-> SYNC_AT_RATIO || SYNC_DONE || SYNC_RAMP_DOWN) else $error("ramp-up end wrong");
	// a restart during the ramp-down leaves it without passing through done
	chk_down_done: assert property ($fell(SYNC_RAMP_DOWN)
		|-> SYNC_DONE || SYNC_RAMP_UP || SYNC_AT_RATIO) else $error("ramp-down end wrong");
endmodule
bind motion_supervisor sup_props #(.POS_W(POS_W)) u_props (.CLK_SYS, .SYS_RST, .PSEL, .PENABLE,
	.PWRITE, .HOLD_IN, .MOVE_INDEX, .SYNC_ACTIVATE, .ZERO_ERR_REQ, .POS_COMMAND, .POS_FEEDBACK,
	.OTHER_FAULT, .INDEX_VEL_FREEZE, .CMD_LOAD, .SYNC_ACTIVE, .SYNC_RAMP_UP, .SYNC_AT_RATIO,
	.SYNC_RAMP_DOWN, .SYNC_DONE, .ERR_FAULT, .NO_FAULT_STATUS);

//--- servo_model.sv
// Purpose: motor feedback behind the supervisor
// Assumes: at most one count of travel per update
// Notes: run low models a disabled bridge holding position
`timescale 1ns/1ns
module servo_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// drive side
	input wire logic [31:0] cmd,
	input wire logic run,
	output logic [31:0] fb
);
	logic [31:0] fb_q;
	assign fb = fb_q;
	always @(posedge clk) begin
		if (rst)
			fb_q <= 32'h0;
		else if (run && fb_q != cmd)
			fb_q <= ($signed(cmd) > $signed(fb_q)) ? fb_q + 32'h1 : fb_q - 32'h1;
	end
endmodule

//--- testbench.sv
// Purpose: self-checking bench of the motion supervisor
// Assumes: bench plays trajectory generator and APB master
// Notes: hold time is shortened to 8 updates
`timescale 1ns/1ns
`include "motion_supervisor_map.vh"
module testbench;
	logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, perr, prdy, hold = 0, rdis = 0;
	logic idx = 0, hom = 0, prg = 0, jog = 0, jprg = 0, act = 0, zreq = 0, ofl = 0, tfl = 0;
	logic run = 0, ld, frz, s_act, s_up, s_rat, s_dn, s_done, efl, nof, serr;
	logic [7:0] padr = 8'h00;
	logic [31:0] pwd = 32'h0, prd, rd, cmd = 32'h0, tinc, fb, ldv, e;
	logic [31:0] pct [4] = '{32'h32, 32'h64, 32'hC8, 32'h1};
	logic [4:0] mv [5] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h03};
	logic [15:0] span, scale, seed = 16'hCD30;
	int bad_count = 0, cmp_count = 0, cyc = 0, n;
	motion_supervisor u_dut (.CLK_SYS(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen),
		.PWRITE(pwr), .PADDR(padr), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
		.HOLD_IN(hold), .RATE_SCALE_DISABLE(rdis), .MOVE_INDEX(idx), .MOVE_HOME(hom),
		.MOVE_PROGRAM(prg), .MOVE_JOG(jog), .JOG_FROM_PROGRAM(jprg), .SYNC_ACTIVATE(act),
		.ZERO_ERR_REQ(zreq), .POS_COMMAND(cmd), .POS_FEEDBACK(fb), .OTHER_FAULT(ofl),
		.TRAVEL_LIMIT_FAULT(tfl), .TIME_INC(tinc), .HOLD_SPAN(span), .INDEX_VEL_FREEZE(frz),
		.CMD_LOAD(ld), .CMD_LOAD_VALUE(ldv), .SYNC_SCALE(scale), .SYNC_ACTIVE(s_act),
		.SYNC_RAMP_UP(s_up), .SYNC_AT_RATIO(s_rat), .SYNC_RAMP_DOWN(s_dn), .SYNC_DONE(s_done),
		.ERR_FAULT(efl), .NO_FAULT_STATUS(nof));
	servo_model u_srv (.clk(clk), .rst(rst), .cmd(cmd), .run(run), .fb(fb));
	initial forever #2 clk = ~clk;
	// trajectory generator takes the load at once
	always @(posedge clk) if (ld === 1'b1) cmd <= ldv;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			bad_count++;
			results();
		end
	end
	function automatic [15:0] nx(input [15:0] s);
		nx = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task results;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task cy(input int k);
		repeat (k) @(posedge clk);
	endtask
	// called just after an edge; waits on pready with no fixed count
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge clk) pen <= 1;
		@(posedge clk);
		while (prdy !== 1'b1) @(posedge clk);
		rd = prd;
		serr = perr;
		psel <= 0;
		pen <= 0;
		@(posedge clk);
	endtask
	initial begin
		cy(16);
		rst <= 0;
		cy(1);
		chk(nof, 1);
		apb(0, `REG_RATE, 0);
		chk(rd, 32'h64);
		apb(0, 8'h20, 0);
		chk(rd, 0);
		chk(serr, 1);
		apb(1, `REG_HOLD_TIME, 8);
		idx <= 1;
		seed = nx(seed);
		pct[3] = {24'h0, seed[7:0]};
		for (int i = 0; i < 4; i++) begin
			apb(1, `REG_RATE, pct[i]);
			cy(2);
			chk(tinc, pct[i] * 8);
		end
		chk(span, 8);
		apb(1, `REG_RATE, 32'h32);
		rdis <= 1;
		cy(3);
		chk(tinc, 800);
		rdis <= 0;
		apb(1, `REG_RATE, 32'h64);
		for (int i = 0; i < 5; i++) begin
			{idx, hom, prg, jog, jprg} <= mv[i];
			cy(3);
			hold <= 1;
			n = 0;
			do begin
				@(posedge clk) #1;
				n++;
			end while (tinc !== 0 && n < 20);
			chk(frz, mv[i][4]);
			chk(tinc, (i == 3) ? 800 : 0);
			if (i != 3)
				chk(n, 8);
			@(posedge clk);
			hold <= 0;
			n = 0;
			do begin
				@(posedge clk) #1;
				n++;
			end while (tinc !== 800 && n < 20);
			chk(n, (i == 3) ? 1 : 8);
			@(posedge clk);
		end
		// zero ramp time: hold stops at once
		apb(1, `REG_HOLD_TIME, 0);
		hold <= 1;
		cy(2);
		chk(tinc, 0);
		hold <= 0;
		cy(2);
		chk(tinc, 32'h64);
		seed = nx(seed);
		e = {22'h0, seed[9:0]} + 32'h2;
		cmd <= e;
		// let the registered error catch up before the read setup
		cy(1);
		apb(0, `REG_POS_ERR, 0);
		chk(rd, e);
		apb(1, `REG_ERR_LIMIT, e);
		apb(1, `REG_CTRL, 1);
		cy(3);
		chk({efl, nof}, 2'b01);
		apb(1, `REG_ERR_LIMIT, e - 1);
		cy(3);
		chk({efl, nof}, 2'b10);
		apb(1, `REG_CTRL, 0);
		apb(1, `REG_STATUS, 1);
		tfl <= 1;
		cy(3);
		chk({efl, nof}, 2'b01);
		ofl <= 1;
		cy(3);
		chk(nof, 0);
		{ofl, tfl, zreq} <= 3'b001;
		cy(1);
		zreq <= 0;
		cy(2);
		chk(ld, 1);
		cy(4);
		chk(ld, 0);
		chk(cmd, fb);
		apb(0, `REG_STATUS, 0);
		chk(rd[`ST_ZERO_REQ], 0);
		act <= 1;
		cy(3);
		chk({s_act, s_up, s_rat, s_dn, s_done}, 5'b10100);
		act <= 0;
		cy(3);
		chk({s_act, s_up, s_rat, s_dn, s_done}, 5'b00001);
		apb(1, `REG_RAMP_UP, 32'h4000);
		apb(1, `REG_RAMP_DOWN, 32'h4000);
		apb(1, `REG_CTRL, 32'h6);
		act <= 1;
		cy(2);
		chk({s_act, s_up, s_rat, s_dn, s_done}, 5'b11000);
		chk(scale, 0);
		cy(8);
		chk({s_act, s_up, s_rat, s_dn, s_done}, 5'b10100);
		chk(scale, 32'hFFFF);
		act <= 0;
		cy(3);
		chk({s_act, s_up, s_rat, s_dn, s_done}, 5'b00001);
		apb(1, `REG_CTRL, 32'hE);
		cy(10);
		apb(1, `REG_CTRL, 32'h6);
		cy(2);
		chk({s_act, s_up, s_rat, s_dn, s_done}, 5'b10010);
		chk(scale, 32'hFFFF - 32'h4000);
		cy(8);
		chk({s_act, s_up, s_rat, s_dn, s_done}, 5'b00001);
		cmd <= e;
		run <= 1;
		cy(1200);
		chk(fb, e);
		apb(0, `REG_POS_ERR, 0);
		chk(rd, 0);
		results();
	end
endmodule
